// ===== shared/xsp_pkg.sv
// Functional notes
// - The generator state lives in one 8-bit register and every output byte is taken from it.
// - The state is replaced on every iteration and each new state is the next output value.
// - A new state is computed from the current one with XOR and shift operations only.
// - Each iteration applies x^=x<<a, then x^=x>>b, then x^=x<<c with fixed constants.
// - All shifts are logical, filling vacated bits with zeros and never rotating.
// - The shift constants are chosen so a nonzero seed runs a long cycle of at most 255 states.
// - The seed passes two synchroniser flops while reset is high, and the first value appears two cycles after reset release.
// - After the latency a fresh pseudorandom byte is offered on the output on every cycle that rand_ready is high.
// - Seed port bit i carries seed bit i and output bit i carries random bit i, for bits 0 to 7.
package xsp_pkg;

  // ----------------------------------------------------------------
  // widths and shapes
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // shift constants
  // ----------------------------------------------------------------
  // full period triple
  localparam int unsigned SHIFT_A = 7;
  localparam int unsigned SHIFT_B = 5;
  localparam int unsigned SHIFT_C = 3;

  // ----------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------
  localparam int unsigned LATENCY_CYC = 2;
  localparam logic [7:0]  OUT_RST     = 8'h00;

  // ----------------------------------------------------------------
  // one generator iteration
  // ----------------------------------------------------------------
  function automatic logic [7:0] xsp_step(input logic [7:0] x);
    logic [7:0] t;
    t = x;
    t = t ^ (t << SHIFT_A);
    t = t ^ (t >> SHIFT_B);
    t = t ^ (t << SHIFT_C);
    return t;
  endfunction : xsp_step

endpackage : xsp_pkg

// ===== hw/xsp_prng.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// output fifo
// ------------------------------------------------------------------
module xsp_fifo #(
  parameter int unsigned WIDTH = xsp_pkg::DATA_W,
  parameter int unsigned DEPTH = xsp_pkg::FIFO_DEPTH
) (
  input  wire logic             mclk,      // clock
  input  wire logic             rst,       // sync reset, high
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // write data
  output logic                  out_valid, // head word present
  input  wire logic             out_ready, // head word taken
  output logic      [WIDTH-1:0] out_data   // head word
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [CW-1:0]    count_ff;
  logic [PW-1:0]    nxt_wr_ptr;
  logic [PW-1:0]    nxt_rd_ptr;
  logic [CW-1:0]    nxt_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count_ff != FULL_CNT);
  assign out_valid = (count_ff != '0);
  assign out_data  = mem[rd_ptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count  = count_ff;
    if (push) begin
      nxt_wr_ptr = (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd_ptr = (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  property p_fifo_bound;
    @(posedge mclk) disable iff (rst)
      (count_ff == FULL_CNT) |-> !push;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo written while full");

endmodule : xsp_fifo

// ------------------------------------------------------------------
// xorshift generator top
// ------------------------------------------------------------------
module xsp_prng (
  input  wire logic       mclk,               // 200 MHz clock
  input  wire logic       rst,                // sync reset, high
  input  wire logic [7:0] seed_input_port,    // seed pins
  input  wire logic       rand_ready,         // consumer takes byte
  output logic      [7:0] random_output_port, // random byte
  output logic            random_valid        // byte on output is valid
);
  logic [7:0] seed_s1_ff;
  logic [7:0] seed_s2_ff;
  logic [7:0] state_ff;
  logic [7:0] nxt_state;
  logic [7:0] out_ff;
  logic [7:0] nxt_out;
  logic       vld_ff;
  logic       nxt_vld;
  logic       gen_push;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic       out_take;

  // ----------------------------------------------------------------
  // seed synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    seed_s1_ff <= seed_input_port;
    seed_s2_ff <= seed_s1_ff;
  end

  // ----------------------------------------------------------------
  // generator state
  // ----------------------------------------------------------------
  // stalls while the fifo is full
  assign gen_push = !rst && fifo_in_ready;

  always_comb begin
    nxt_state = state_ff;
    if (rst) begin
      nxt_state = seed_s2_ff;
    end else if (gen_push) begin
      nxt_state = xsp_pkg::xsp_step(state_ff);
    end
  end

  always_ff @(posedge mclk) begin
    state_ff <= nxt_state;
  end

  xsp_fifo #(
    .WIDTH (xsp_pkg::DATA_W),
    .DEPTH (xsp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (gen_push),
    .in_ready  (fifo_in_ready),
    .in_data   (nxt_state),
    .out_valid (fifo_out_valid),
    .out_ready (out_take),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // output register
  // ----------------------------------------------------------------
  // fifo plus output stage
  assign out_take = fifo_out_valid && (!vld_ff || rand_ready);

  always_comb begin
    nxt_out = out_ff;
    nxt_vld = vld_ff;
    if (out_take) begin
      nxt_out = fifo_out_data;
      nxt_vld = 1'b1;
    end else if (rand_ready) begin
      nxt_vld = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      out_ff <= xsp_pkg::OUT_RST;
      vld_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      vld_ff <= nxt_vld;
    end
  end

  assign random_output_port = out_ff;
  assign random_valid       = vld_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_seed_load;
    @(posedge mclk) disable iff (rst)
      $fell(rst) |-> state_ff == $past(seed_s2_ff);
  endproperty
  a_seed_load: assert property (p_seed_load) else $error("state not loaded from seed");

  property p_iterate;
    @(posedge mclk) disable iff (rst)
      gen_push |=> state_ff == xsp_pkg::xsp_step($past(state_ff));
  endproperty
  a_iterate: assert property (p_iterate) else $error("state not stepped");

  property p_stall;
    @(posedge mclk) disable iff (rst)
      !fifo_in_ready |=> $stable(state_ff);
  endproperty
  a_stall: assert property (p_stall) else $error("state moved while stalled");

  property p_nonzero;
    @(posedge mclk) disable iff (rst)
      (state_ff != 8'h00) |=> (state_ff != 8'h00);
  endproperty
  a_nonzero: assert property (p_nonzero) else $error("nonzero state went to zero");

  property p_latency;
    @(posedge mclk) disable iff (rst)
      $fell(rst) |-> ##2 (random_valid &&
        random_output_port == xsp_pkg::xsp_step($past(state_ff, 2)));
  endproperty
  a_latency: assert property (p_latency) else $error("first value late or wrong");

  property p_fresh;
    @(posedge mclk) disable iff (rst)
      (random_valid && rand_ready && fifo_out_valid && random_output_port != 8'h00) |=>
        (random_valid && random_output_port != $past(random_output_port));
  endproperty
  a_fresh: assert property (p_fresh) else $error("output not refreshed");

  property p_hold;
    @(posedge mclk) disable iff (rst)
      (random_valid && !rand_ready) |=> (random_valid && $stable(random_output_port));
  endproperty
  a_hold: assert property (p_hold) else $error("output changed while held");

  property p_chain;
    @(posedge mclk) disable iff (rst)
      (random_valid && rand_ready && fifo_out_valid) ##1 (random_valid && rand_ready &&
        fifo_out_valid) |-> ##1 random_output_port ==
        xsp_pkg::xsp_step($past(random_output_port));
  endproperty
  a_chain: assert property (p_chain) else $error("outputs not successive states");

endmodule : xsp_prng

// ===== test/xsp_seed_src.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// seed switches on the far side
// ------------------------------------------------------------------
module xsp_seed_src (
  input  wire logic       mclk,     // clock
  input  wire logic       rst,      // reset seen by the generator
  input  wire logic [7:0] seed_req, // seed chosen by the bench
  output logic      [7:0] seed_out  // seed pins
);
  initial seed_out = 8'h00;

  always @(posedge mclk) begin
    if (rst) begin
      seed_out <= seed_req;
    end else begin
      // after release the pins wander so a late sample shows up
      seed_out <= seed_out + 8'h5b;
    end
  end
endmodule : xsp_seed_src

// ===== test/test_xorshift_prng_8bit.sv
`timescale 1ns/1ps

module test_xorshift_prng_8bit;
  logic       mclk;
  logic       rst;
  logic       rand_ready;
  logic [7:0] seed_req;
  logic [7:0] seed_pins;
  logic [7:0] rnd;
  logic       rnd_valid;
  logic       pv;
  logic       pr;
  logic [7:0] pd;
  logic [7:0] s;
  int         n_errors;
  int         checks;
  int         seed;
  int         k;
  int         rcnt;
  int         cyc;
  int         expv;

  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  xsp_seed_src u_src (.mclk(mclk), .rst(rst), .seed_req(seed_req), .seed_out(seed_pins));

  xsp_prng uut (
    .mclk               (mclk),
    .rst                (rst),
    .seed_input_port    (seed_pins),
    .rand_ready         (rand_ready),
    .random_output_port (rnd),
    .random_valid       (rnd_valid)
  );

  // ----------------------------------------------------------------
  // reference model and reporting
  // ----------------------------------------------------------------
  function automatic int nstep(input int x);
    int t;
    t = x & 255;
    t = (t ^ (t << xsp_pkg::SHIFT_A)) & 255;
    t = (t ^ (t >> xsp_pkg::SHIFT_B)) & 255;
    t = (t ^ (t << xsp_pkg::SHIFT_C)) & 255;
    return t;
  endfunction : nstep

  task check(input string name, input logic [7:0] seen, input logic [7:0] expd);
    checks++;
    if (seen !== expd) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, expd, seen);
    end
  endtask : check

  task end_sim;
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // monitor on every edge, values as sampled
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (cyc >= 20000) begin
      n_errors++;
      end_sim();
    end
    if (rst) begin
      rcnt++;
      k = 0;
      if (rcnt > 1) begin
        check("valid_in_reset", {7'h00, rnd_valid}, 8'h00);
        check("out_in_reset", rnd, xsp_pkg::OUT_RST);
      end
    end else begin
      rcnt = 0;
      if (k < xsp_pkg::LATENCY_CYC) check("valid_early", {7'h00, rnd_valid}, 8'h00);
      if (k == xsp_pkg::LATENCY_CYC) check("valid_on_time", {7'h00, rnd_valid}, 8'h01);
      if (pv && !pr) check("held_byte", rnd, pd);
      if (pv && !pr) check("held_valid", {7'h00, rnd_valid}, 8'h01);
      if (rnd_valid && rand_ready) begin
        check("random_byte", rnd, expv[7:0]);
        expv = nstep(expv);
      end
      k++;
    end
    pv = rnd_valid;
    pr = rand_ready;
    pd = rnd;
  end

  // ----------------------------------------------------------------
  // one seeded run: 0 random ready, 1 long stall, 2 always ready
  // ----------------------------------------------------------------
  task run(input logic [7:0] sd, input int mode);
    @(posedge mclk);
    rst        <= 1'b1;
    seed_req   <= sd;
    rand_ready <= 1'b0;
    repeat (16) @(posedge mclk);
    expv = nstep(int'(sd));
    rst <= 1'b0;
    for (int j = 0; j < 300; j++) begin
      @(posedge mclk);
      if (mode == 2) rand_ready <= 1'b1;
      else if (mode == 1) rand_ready <= (j >= 30);
      else rand_ready <= 1'($random(seed));
    end
  endtask : run

  initial begin
    seed       = 39464;
    rst        = 1'b1;
    rand_ready = 1'b0;
    seed_req   = 8'h00;
    n_errors   = 0;
    checks     = 0;
    k          = 0;
    rcnt       = 0;
    cyc        = 0;
    expv       = 0;
    for (int i = 0; i < 5; i++) begin
      s = 8'($random(seed));
      if (s == 8'h00) s = 8'h01;
      // the all-zero seed run breaks the seed duty on purpose
      if (i == 3) s = 8'h00;
      if (i == 4) s = 8'hff;
      run(s, (i < 3) ? i : 0);
    end
    end_sim();
  end
endmodule : test_xorshift_prng_8bit
